/* File: pkg/atfs_pkg.sv */
package atfs_pkg;
  // register offsets (task file index)
  localparam logic [3:0] OFS_CYL_LOW   = 4'h4;
  localparam logic [3:0] OFS_CYL_HIGH  = 4'h5;
  localparam logic [3:0] OFS_UNIT_HEAD = 4'h6;
  localparam logic [3:0] OFS_STATUS    = 4'h7;
  localparam logic [3:0] OFS_CONTROL   = 4'hE;
  localparam logic [3:0] OFS_UNIT_ADDR = 4'hF;
  // unit/head select fields
  localparam int UH_LINEAR_POS = 6;
  localparam int UH_UNIT_POS   = 4;
  localparam logic [7:0] UH_FIXED_ONES = 8'hA0;
  // status fields
  localparam int ST_BUSY_POS  = 7;
  localparam int ST_READY_POS = 6;
  localparam int ST_WF_POS    = 5;
  localparam int ST_SEEK_POS  = 4;
  localparam int ST_DRQ_POS   = 3;
  localparam int ST_FIX_POS   = 2;
  localparam int ST_IDX_POS   = 1;
  localparam int ST_ERR_POS   = 0;
  // control fields
  localparam int CT_SRST_POS  = 2;
  localparam int CT_NIEN_POS  = 1;
  // reset values
  localparam logic [7:0] CYL_RESET       = 8'h00;
  localparam logic [7:0] UNIT_HEAD_RESET = 8'hA0;
  localparam logic [7:0] ZERO8           = 8'h00;
  // diagnostic code loaded by soft reset
  localparam logic [7:0] DIAG_CODE       = 8'h01;
endpackage

/* File: verilog/atfs_flag.sv */
`timescale 1ns/1ps
// sticky flag: set wins over clear
module atfs_flag (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // control
  input  wire logic i_set,
  input  wire logic i_clr,
  // state
  output logic      o_q
);
  logic q_r;
  logic q_nxt;
  always_comb begin
    q_nxt = q_r;
    if (i_clr) begin
      q_nxt = 1'b0;
    end
    if (i_set) begin
      q_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign o_q = q_r;
endmodule

/* File: verilog/atfs_reg8.sv */
`timescale 1ns/1ps
// byte register with load and reset value
module atfs_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  // load
  input  wire logic       i_load,
  input  wire logic [7:0] i_d,
  // state
  output logic      [7:0] o_q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;
  always_comb begin
    q_nxt = i_load ? i_d : q_r;
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q_r <= RESET_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign o_q = q_r;
endmodule

/* File: verilog/atfs_regs.sv */
`timescale 1ns/1ps
//
// Contract
// - cylinder low: cylinder low bits or address 15..8
// - cylinder high: cylinder high or address 23..16
// - bit 6 picks linear mode; 7,5 read one
// - linear address built from four registers
// - geometry mode: bits 3..0 form head number
// - bit 4 selects unit; respond on match
// - status read clears interrupt; shadow read keeps
// - busy hides other bits, refuses host writes except to control
// - ready after power-up; seek complete when ready
// - bit 5 shows write fault
// - data request set; cleared by next command
// - corrected data flag, read continues
// - index bit always reads zero
// - error flag; cleared by next command
// - control register writable even while busy
// - soft reset clears status, loads diagnostic
// - interrupt disable bit, powers on zero
// - write in progress reads zero at bit 6
// - readback bits 5..2 invert head bits
// - readback bits 1,0 low for selected unit
//
module atfs_regs (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // task file access port
  input  wire logic [3:0]  i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  // card configuration
  input  wire logic        i_unit_number,
  // core events and state
  input  wire logic        i_busy,
  input  wire logic        i_ready,
  input  wire logic        i_write_fault,
  input  wire logic        i_drq_set,
  input  wire logic        i_fixed_set,
  input  wire logic        i_err_set,
  input  wire logic        i_irq_event,
  input  wire logic        i_write_active,
  input  wire logic        i_cmd_issued,
  input  wire logic        i_fail_load,
  input  wire logic [27:0] i_fail_addr,
  input  wire logic [7:0]  i_sector_number,
  // outputs to core and host
  output logic [27:0]      o_block_addr,
  output logic [3:0]       o_head,
  output logic             o_linear_mode,
  output logic             o_selected,
  output logic             o_soft_reset,
  output logic [7:0]       o_diag_code,
  output logic             o_irq_disable,
  output logic             o_interrupt_request_n
);
  // ==========================================
  // access decode
  logic sel_ok;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] cyl_low_q;
  logic [7:0] cyl_high_q;
  logic [7:0] uh_q;
  logic       unit_match;
  logic       wr_cyl_low;
  logic       wr_cyl_high;
  logic       wr_uh;
  logic       wr_ctl;
  assign unit_match = (uh_q[atfs_pkg::UH_UNIT_POS] == i_unit_number);
  assign sel_ok     = unit_match;
  // refused writes drop silently; the host polls busy first
  // busy refuses writes except to control
  assign wr_ok      = i_wr && sel_ok && !i_busy;
  assign rd_ok      = i_rd && sel_ok;
  assign wr_cyl_low  = wr_ok && (i_addr == atfs_pkg::OFS_CYL_LOW);
  assign wr_cyl_high = wr_ok && (i_addr == atfs_pkg::OFS_CYL_HIGH);
  // unit/head write is honoured by both units so selection can move
  assign wr_uh       = i_wr && !i_busy && (i_addr == atfs_pkg::OFS_UNIT_HEAD);
  assign wr_ctl      = i_wr && (i_addr == atfs_pkg::OFS_CONTROL);

  // ==========================================
  // address registers
  logic [7:0] cyl_low_d;
  logic [7:0] cyl_high_d;
  logic [7:0] uh_d;
  // bits 7 and 5 forced high
  // a core reload beats a host write in the same cycle
  always_comb begin
    if (i_fail_load) begin
      cyl_low_d  = i_fail_addr[15:8];
      cyl_high_d = i_fail_addr[23:16];
      uh_d       = {uh_q[7:4], i_fail_addr[27:24]} | atfs_pkg::UH_FIXED_ONES;
    end else begin
      cyl_low_d  = i_wdata;
      cyl_high_d = i_wdata;
      uh_d       = i_wdata | atfs_pkg::UH_FIXED_ONES;
    end
  end

  atfs_reg8 #(.RESET_VAL(atfs_pkg::CYL_RESET)) u_cyl_low (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_load    (wr_cyl_low || i_fail_load),
    .i_d       (cyl_low_d),
    .o_q       (cyl_low_q)
  );
  atfs_reg8 #(.RESET_VAL(atfs_pkg::CYL_RESET)) u_cyl_high (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_load    (wr_cyl_high || i_fail_load),
    .i_d       (cyl_high_d),
    .o_q       (cyl_high_q)
  );
  atfs_reg8 #(.RESET_VAL(atfs_pkg::UNIT_HEAD_RESET)) u_unit_head (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_load    (wr_uh || i_fail_load),
    .i_d       (uh_d),
    .o_q       (uh_q)
  );

  assign o_linear_mode = uh_q[atfs_pkg::UH_LINEAR_POS];
  assign o_block_addr  = {uh_q[3:0], cyl_high_q, cyl_low_q, i_sector_number};
  assign o_head        = uh_q[3:0];
  assign o_selected    = unit_match;

  // ==========================================
  // control register
  logic srst_r;
  logic srst_nxt;
  logic nien_r;
  logic nien_nxt;
  logic [7:0] diag_r;
  logic [7:0] diag_nxt;
  always_comb begin
    srst_nxt = srst_r;
    nien_nxt = nien_r;
    diag_nxt = diag_r;
    if (wr_ctl) begin
      srst_nxt = i_wdata[atfs_pkg::CT_SRST_POS];
      nien_nxt = i_wdata[atfs_pkg::CT_NIEN_POS];
      // code stays until power-on reset; the error register lives elsewhere
      if (i_wdata[atfs_pkg::CT_SRST_POS]) begin
        diag_nxt = atfs_pkg::DIAG_CODE;
      end
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      srst_r <= 1'b0;
      nien_r <= 1'b0;
      diag_r <= atfs_pkg::ZERO8;
    end else begin
      srst_r <= srst_nxt;
      nien_r <= nien_nxt;
      diag_r <= diag_nxt;
    end
  end
  assign o_soft_reset  = srst_r;
  assign o_irq_disable = nien_r;
  assign o_diag_code   = diag_r;

  // ==========================================
  // status flags
  logic flag_clr;
  logic drq_q;
  logic fixed_q;
  logic err_q;
  logic irq_q;
  logic status_rd;
  // next command or soft reset clears
  assign flag_clr  = i_cmd_issued || srst_r;
  assign status_rd = rd_ok && (i_addr == atfs_pkg::OFS_STATUS);

  atfs_flag u_drq (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_set     (i_drq_set && !srst_r),
    .i_clr     (flag_clr),
    .o_q       (drq_q)
  );
  // corrected data, does not stop core
  atfs_flag u_fixed (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_set     (i_fixed_set && !srst_r),
    .i_clr     (flag_clr),
    .o_q       (fixed_q)
  );
  atfs_flag u_err (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_set     (i_err_set && !srst_r),
    .i_clr     (flag_clr),
    .o_q       (err_q)
  );
  atfs_flag u_irq (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_set     (i_irq_event && !srst_r),
    .i_clr     (status_rd || srst_r),
    .o_q       (irq_q)
  );

  assign o_interrupt_request_n = !(irq_q && !nien_r);

  // ==========================================
  // readback levels
  logic write_in_progress_n;
  logic unit1_selected_n;
  logic unit0_selected_n;
  assign write_in_progress_n = !i_write_active;
  assign unit1_selected_n    = !(i_unit_number && unit_match);
  assign unit0_selected_n    = !(!i_unit_number && unit_match);

  // ==========================================
  // read path
  logic [7:0] status_v;
  logic [7:0] readback_v;
  logic       ready_v;
  always_comb begin
    status_v = atfs_pkg::ZERO8;
    // soft reset shows a cleared status apart from busy
    ready_v  = i_ready && !srst_r;
    if (i_busy || srst_r) begin
      status_v[atfs_pkg::ST_BUSY_POS] = 1'b1;
    end else begin
      status_v[atfs_pkg::ST_READY_POS] = ready_v;
      status_v[atfs_pkg::ST_SEEK_POS]  = ready_v;
      status_v[atfs_pkg::ST_WF_POS]    = i_write_fault;
      status_v[atfs_pkg::ST_DRQ_POS]   = drq_q;
      status_v[atfs_pkg::ST_FIX_POS]   = fixed_q;
      status_v[atfs_pkg::ST_IDX_POS]   = 1'b0;
      status_v[atfs_pkg::ST_ERR_POS]   = err_q;
    end
  end
  always_comb begin
    // bit 7 undefined, driven zero
    readback_v    = atfs_pkg::ZERO8;
    readback_v[6] = write_in_progress_n;
    readback_v[5:2] = ~uh_q[3:0];
    readback_v[1] = unit1_selected_n;
    readback_v[0] = unit0_selected_n;
  end

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_ok) begin
      unique case (i_addr)
        atfs_pkg::OFS_CYL_LOW:   rdata_nxt = i_busy ? status_v : cyl_low_q;
        atfs_pkg::OFS_CYL_HIGH:  rdata_nxt = i_busy ? status_v : cyl_high_q;
        atfs_pkg::OFS_UNIT_HEAD: rdata_nxt = i_busy ? status_v : uh_q;
        atfs_pkg::OFS_STATUS:    rdata_nxt = status_v;
        atfs_pkg::OFS_CONTROL:   rdata_nxt = status_v;
        atfs_pkg::OFS_UNIT_ADDR: rdata_nxt = readback_v;
        default:                 rdata_nxt = atfs_pkg::ZERO8;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= atfs_pkg::ZERO8;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign o_rdata = rdata_r;
endmodule

/* File: dv/atfs_regs_properties.sv */
`timescale 1ns/1ps
// ====================
// checker on the task file ports
module atfs_regs_properties (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_busy,
  input wire logic        i_ready,
  input wire logic        i_irq_event,
  input wire logic        i_write_active,
  input wire logic [7:0]  i_sector_number,
  input wire logic [27:0] o_block_addr,
  input wire logic [3:0]  o_head,
  input wire logic        o_selected,
  input wire logic        o_soft_reset,
  input wire logic        o_irq_disable,
  input wire logic        o_interrupt_request_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic sel_rd7 = i_rd && (i_addr == 4'h7) && o_selected;
  a_fixed_ones: assert property (i_rd && i_addr == 4'h6 && o_selected && !i_busy && !o_soft_reset
    |=> o_rdata[7] && o_rdata[5]) else $error("unit head fixed bits wrong");
  a_linear_addr: assert property (o_block_addr[7:0] == i_sector_number && o_block_addr[27:24] == o_head)
    else $error("block address assembly wrong");
  a_status_clear: assert property (sel_rd7 && !i_busy && !i_irq_event |=> o_interrupt_request_n)
    else $error("status read kept interrupt");
  a_shadow_keep: assert property (i_rd && i_addr == 4'hE && !i_wr && !o_interrupt_request_n
    |=> !o_interrupt_request_n) else $error("shadow read cleared interrupt");
  a_busy_status: assert property (sel_rd7 && i_busy |=> o_rdata[7]) else $error("busy not shown");
  a_ready_seek: assert property (sel_rd7 && i_ready && !i_busy && !o_soft_reset
    |=> o_rdata[6] && o_rdata[4]) else $error("ready or seek bit low");
  a_index_zero: assert property (sel_rd7 |=> !o_rdata[1]) else $error("index bit set");
  a_ctrl_write: assert property (i_wr && i_addr == 4'hE
    |=> o_irq_disable == $past(i_wdata[1]) && o_soft_reset == $past(i_wdata[2])) else $error("control write lost");
  a_irq_gate: assert property (!o_interrupt_request_n |-> !o_irq_disable) else $error("masked irq driven");
  a_readback_inv: assert property (i_rd && i_addr == 4'hF && o_selected
    |=> o_rdata[5:2] == ~$past(o_head) && o_rdata[6] == !$past(i_write_active)) else $error("readback wrong");
  c_busy_read: cover property (sel_rd7 && i_busy);
  c_irq_up: cover property (!o_interrupt_request_n);
  c_ctrl_busy: cover property (i_wr && i_addr == 4'hE && i_busy);
endmodule
bind atfs_regs atfs_regs_properties PROPS (.*);

/* File: dv/atfs_host.sv */
`timescale 1ns/1ps
// ====================
// host side: byte strobes, one per access
module atfs_host (
  input  wire logic       i_clk_sys,
  output logic      [3:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 4'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'hFF;
  end
  // params before command
  // released bus shows inverse, so stale data never looks valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge i_clk_sys);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule

/* File: dv/atfs_regs_tb.sv */
`timescale 1ns/1ps
// ====================
// task file bench
module atfs_regs_tb;
  logic        i_clk_sys, i_reset, i_rd, i_wr, i_unit_number, i_busy, i_ready, i_write_fault;
  logic        i_drq_set, i_fixed_set, i_err_set, i_irq_event, i_write_active, i_cmd_issued, i_fail_load;
  logic        o_linear_mode, o_selected, o_soft_reset, o_irq_disable, o_interrupt_request_n;
  logic [3:0]  i_addr, o_head;
  logic [7:0]  i_wdata, o_rdata, i_sector_number, o_diag_code;
  logic [27:0] i_fail_addr, o_block_addr;
  int          n_fail, n_compared;
  atfs_regs DUT (.*);
  atfs_host HOST (.i_clk_sys(i_clk_sys), .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pls(ref logic s);
    @(negedge i_clk_sys);
    s = 1'b1;
    @(negedge i_clk_sys);
    s = 1'b0;
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====================
  // watchdog: whole run is under a hundred cycles
  initial begin
    #40000;
    n_fail++;
    results();
  end
  initial begin
    {i_unit_number, i_busy, i_ready, i_write_fault, i_drq_set, i_fixed_set} = 6'h00;
    {i_err_set, i_irq_event, i_write_active, i_cmd_issued, i_fail_load} = 5'h00;
    i_sector_number = 8'h3C;
    i_fail_addr = 28'h0000000;
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    i_reset = 1'b0;
    chk("irq_dis", 1'b0, o_irq_disable);
    chk("soft_reset", 1'b0, o_soft_reset);
    chk("irq_n", 1'b1, o_interrupt_request_n);
    HOST.rd(4'h7);
    chk("status", 8'h00, o_rdata);
    HOST.rd(4'h6);
    chk("unit_head", 8'hA0, o_rdata);
    HOST.rd(4'hF);
    chk("readback", 8'h7E, o_rdata);
    HOST.wr(4'h4, 8'h5A);
    HOST.wr(4'h5, 8'hC3);
    HOST.wr(4'h6, 8'hE9);
    chk("block_addr", {4'h9, 8'hC3, 8'h5A, 8'h3C}, o_block_addr);
    chk("linear", 1'b1, o_linear_mode);
    HOST.rd(4'hF);
    chk("readback", 8'h5A, o_rdata);
    HOST.wr(4'h6, 8'hB9);
    chk("head", 4'h9, o_head);
    chk("linear", 1'b0, o_linear_mode);
    chk("selected", 1'b0, o_selected);
    i_unit_number = 1'b1;
    i_write_active = 1'b1;
    HOST.rd(4'hF);
    chk("readback", 8'h19, o_rdata);
    i_unit_number = 1'b0;
    i_write_active = 1'b0;
    HOST.wr(4'h6, 8'hE9);
    i_ready = 1'b1;
    i_write_fault = 1'b1;
    pls(i_drq_set);
    pls(i_fixed_set);
    pls(i_err_set);
    HOST.rd(4'h7);
    chk("status", 8'h7D, o_rdata);
    pls(i_cmd_issued);
    i_write_fault = 1'b0;
    HOST.rd(4'h7);
    chk("status_req_err", 8'h00, o_rdata & 8'h09);
    pls(i_irq_event);
    chk("irq_n", 1'b0, o_interrupt_request_n);
    HOST.rd(4'hE);
    chk("irq_n", 1'b0, o_interrupt_request_n);
    HOST.wr(4'hE, 8'h02);
    chk("irq_n", 1'b1, o_interrupt_request_n);
    chk("irq_dis", 1'b1, o_irq_disable);
    HOST.wr(4'hE, 8'h00);
    chk("irq_n", 1'b0, o_interrupt_request_n);
    HOST.rd(4'h7);
    chk("irq_n", 1'b1, o_interrupt_request_n);
    pls(i_err_set);
    pls(i_drq_set);
    i_busy = 1'b1;
    HOST.wr(4'h4, 8'hFF);
    HOST.wr(4'hE, 8'h04);
    chk("soft_reset", 1'b1, o_soft_reset);
    chk("diag", 8'h01, o_diag_code);
    HOST.rd(4'h7);
    chk("status", 8'h80, o_rdata);
    i_busy = 1'b0;
    HOST.wr(4'hE, 8'h00);
    HOST.rd(4'h4);
    chk("cyl_low", 8'h5A, o_rdata);
    HOST.rd(4'h7);
    chk("status", 8'h50, o_rdata);
    i_fail_addr = 28'h1234567;
    pls(i_fail_load);
    chk("fail_addr", 20'h12345, o_block_addr[27:8]);
    i_sector_number = 8'hA5;
    @(negedge i_clk_sys);
    chk("block_addr", {4'h1, 8'h23, 8'h45, 8'hA5}, o_block_addr);
    results();
  end
endmodule
